// ### sofr_top.sv
// Notes on behaviour
// R1: exactly one trigger high turns the main converter on, audio or not.
// R2: both triggers high forces standby, even with audio present.
// R3: triggers low, audio above about 1.3 mV keeps main converter on.
// R4: triggers low, 13 minutes without audio returns main converter to standby.
// R5: triggers low, audio detection moves standby to on.
// R6: on-to-standby change waits 200 ms before main converter stops.
// R7: five main-converter sensors raise a shared clip request, not a stop.
// R8: clipping that fails to restore safe operation forces main converter off.
// R9: a forced shutdown holds main off about 9 s, then restarts.
// R10: output offset fault stops main converter at once for 9 s.
// R11: offset still present after restart repeats the off-restart cycle.
// R12: excessive average current held for the safe time raises clip gradually.
// R13: heatsinks, rail undervoltage, aux heat, pump current raise clip gradually.
// R14: aux overcurrent stops aux converter briefly, retrying while shorted.
// R15: standby short stops standby converter briefly, retrying while shorted.
// R16: standby converter low power in standby, full capability when on.
// R17: indicator shows two states, on and standby.
// R18: aux outputs stay disabled in standby.
// R19: reset starts in standby, timers cleared, intervals counted in ticks.
// R20: audio restarts inactivity timer; forced-off beats any on request.
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module sofr_top #(
  parameter logic [sofr_pkg::CNT_W-1:0] TICK_CYCLES =
    sofr_pkg::CNT_W'(sofr_pkg::TICK_CYC),
  parameter logic [sofr_pkg::CNT_W-1:0] INACT_TICKS =
    sofr_pkg::CNT_W'(sofr_pkg::INACT_MS),
  parameter logic [sofr_pkg::CNT_W-1:0] FORCED_TICKS =
    sofr_pkg::CNT_W'(sofr_pkg::FORCED_MS)
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // triggers and audio sense
  input wire logic hv_trigger_input,
  input wire logic logic_level_trigger_input,
  input wire logic audio_detect,
  // main converter sensors
  input wire logic heatsink_pri_hot,
  input wire logic heatsink_sec_hot,
  input wire logic avg_current_high,
  input wire logic positive_power_rail_low,
  input wire logic negative_power_rail_low,
  input wire logic amp_dc_offset,
  // auxiliary and standby sensors
  input wire logic aux_device_hot,
  input wire logic pump_cancel_overcurrent,
  input wire logic aux_overcurrent,
  input wire logic standby_rail_short,
  // converter controls
  output logic main_conv_en,
  output logic aux_conv_en,
  output logic standby_rail_en,
  output logic standby_full_power,
  output logic clip_request,
  output logic [7:0] clip_level,
  // indicator
  output logic led_on_mode,
  output logic led_standby_mode,
  // axi4-lite write
  input wire logic [sofr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [sofr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int unsigned W = sofr_pkg::CNT_W;

  sofr_tick_if tk ();
  logic [sofr_pkg::IN_N-1:0] raw;
  logic [sofr_pkg::IN_N-1:0] s1_q;
  logic [sofr_pkg::IN_N-1:0] s2_q;
  logic hv_s, ll_s, audio_s, dc_s, avg_s;
  logic trig_on, both_trig, req_on, recent, clip_src, avg_trip, clip_trip;
  logic sense_en;
  logic [31:0] ctrl_q;
  logic seen_q, mode_on_q, forced_q;
  logic [W-1:0] inact_q, off_cnt_q, force_cnt_q, avg_cnt_q, sat_cnt_q;
  logic [7:0] clip_q;
  logic aux_run, stb_run;
  logic aw_got_q, w_got_q;
  logic [sofr_pkg::ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] status;

  sofr_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .aclk(aclk),
    .aresetn(aresetn),
    .tk(tk)
  );

  // every sensor is asynchronous to aclk
  assign raw = {standby_rail_short, aux_overcurrent, amp_dc_offset,
                pump_cancel_overcurrent, aux_device_hot,
                negative_power_rail_low, positive_power_rail_low,
                avg_current_high, heatsink_sec_hot, heatsink_pri_hot,
                audio_detect, logic_level_trigger_input, hv_trigger_input};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  assign hv_s = s2_q[sofr_pkg::IX_HV];
  assign ll_s = s2_q[sofr_pkg::IX_LL];
  assign audio_s = s2_q[sofr_pkg::IX_AUDIO] && sense_en;
  assign dc_s = s2_q[sofr_pkg::IX_DC];
  assign avg_s = s2_q[sofr_pkg::IX_AVG];
  assign sense_en = ctrl_q[sofr_pkg::CTRL_SENSE_EN];

  assign trig_on = hv_s ^ ll_s; // R1
  assign both_trig = hv_s && ll_s; // R2
  assign recent = seen_q && (inact_q < INACT_TICKS); // R4
  assign req_on = !both_trig && (trig_on || audio_s || recent); // R2 R3 R5

  // inactivity timer; a fresh detection restarts it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      seen_q <= 1'b0;
      inact_q <= '0;
    end
    else if (audio_s)
    begin
      seen_q <= 1'b1;
      inact_q <= '0; // R20
    end
    else if (tk.ms_tick && recent)
      inact_q <= inact_q + 1'b1; // R4
  end

  // off delay lets standby-rail loads power down first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_on_q <= 1'b0; // R19
      off_cnt_q <= '0;
    end
    else if (req_on)
    begin
      mode_on_q <= 1'b1; // R1 R3 R5
      off_cnt_q <= '0;
    end
    else if (mode_on_q && tk.ms_tick)
    begin
      if (off_cnt_q == W'(sofr_pkg::OFF_DELAY_MS - 1))
      begin
        mode_on_q <= 1'b0; // R6
        off_cnt_q <= '0;
      end
      else
        off_cnt_q <= off_cnt_q + 1'b1;
    end
  end

  // average current counts only after the safe time has passed
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !avg_s)
      avg_cnt_q <= '0;
    else if (tk.ms_tick && !avg_trip)
      avg_cnt_q <= avg_cnt_q + 1'b1; // R12
  end
  assign avg_trip = avg_cnt_q == W'(sofr_pkg::AVG_SAFE_MS);

  assign clip_src = s2_q[sofr_pkg::IX_HS_PRI] || s2_q[sofr_pkg::IX_HS_SEC] ||
                    avg_trip || s2_q[sofr_pkg::IX_POS_UV] ||
                    s2_q[sofr_pkg::IX_NEG_UV] || s2_q[sofr_pkg::IX_AUX_HOT] ||
                    s2_q[sofr_pkg::IX_PUMP]; // R7 R13

  // one step per tick keeps the audible change gradual
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      clip_q <= '0;
    else if (tk.ms_tick && clip_src && clip_q != sofr_pkg::CLIP_MAX)
      clip_q <= clip_q + 1'b1; // R12 R13
    else if (tk.ms_tick && !clip_src && clip_q != 8'h00)
      clip_q <= clip_q - 1'b1;
  end

  // full clip that still does not clear the fault is a last resort
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !clip_src || clip_q != sofr_pkg::CLIP_MAX || forced_q)
      sat_cnt_q <= '0;
    else if (tk.ms_tick && !clip_trip)
      sat_cnt_q <= sat_cnt_q + 1'b1;
  end
  assign clip_trip = sat_cnt_q == W'(sofr_pkg::CLIP_SAT_MS); // R8

  // forced-off window; only raised while the converter runs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      forced_q <= 1'b0;
      force_cnt_q <= '0;
    end
    else if (!forced_q)
    begin
      force_cnt_q <= '0;
      if (main_conv_en && (dc_s || clip_trip))
        forced_q <= 1'b1; // R8 R10 R11
    end
    else if (tk.ms_tick)
    begin
      if (force_cnt_q == FORCED_TICKS - 1'b1)
        forced_q <= 1'b0; // R9 R10
      else
        force_cnt_q <= force_cnt_q + 1'b1;
    end
  end

  sofr_retry u_aux (
    .aclk(aclk),
    .aresetn(aresetn),
    .tk(tk),
    .en_req(mode_on_q), // R18
    .fault(s2_q[sofr_pkg::IX_AUX_OC]), // R14
    .run_q(aux_run)
  );

  sofr_retry u_stb (
    .aclk(aclk),
    .aresetn(aresetn),
    .tk(tk),
    .en_req(1'b1),
    .fault(s2_q[sofr_pkg::IX_STB_SC]), // R15
    .run_q(stb_run)
  );

  // registered converter outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      main_conv_en <= 1'b0;
      aux_conv_en <= 1'b0;
      standby_rail_en <= 1'b0;
      standby_full_power <= 1'b0;
      clip_request <= 1'b0;
      clip_level <= '0;
      led_on_mode <= 1'b0;
      led_standby_mode <= 1'b1;
    end
    else
    begin
      main_conv_en <= mode_on_q && !forced_q; // R20
      aux_conv_en <= aux_run && mode_on_q; // R18
      standby_rail_en <= stb_run;
      standby_full_power <= mode_on_q; // R16
      clip_request <= clip_q != 8'h00; // R7
      clip_level <= clip_q;
      led_on_mode <= mode_on_q; // R17
      led_standby_mode <= !mode_on_q; // R17
    end
  end

  // axi4-lite write: address and data taken in either order
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready = !w_got_q && !s_axi_bvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sofr_pkg::RESP_OKAY;
      ctrl_q <= sofr_pkg::CTRL_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (aw_got_q && w_got_q)
      begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if ({awaddr_q[7:2], 2'b00} == sofr_pkg::OFS_CTRL)
        begin
          s_axi_bresp <= sofr_pkg::RESP_OKAY;
          if (wstrb_q[0])
            ctrl_q[sofr_pkg::CTRL_SENSE_EN] <=
              wdata_q[sofr_pkg::CTRL_SENSE_EN];
        end
        else if ({awaddr_q[7:2], 2'b00} == sofr_pkg::OFS_STATUS ||
                 {awaddr_q[7:2], 2'b00} == sofr_pkg::OFS_CLIP)
          s_axi_bresp <= sofr_pkg::RESP_OKAY;
        else
          s_axi_bresp <= sofr_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_comb
  begin
    status = '0;
    status[sofr_pkg::ST_MODE_ON] = mode_on_q;
    status[sofr_pkg::ST_MAIN_EN] = main_conv_en;
    status[sofr_pkg::ST_FORCED] = forced_q;
    status[sofr_pkg::ST_AUX_EN] = aux_conv_en;
    status[sofr_pkg::ST_STB_RUN] = standby_rail_en;
    status[sofr_pkg::ST_STB_FULL] = standby_full_power;
    status[sofr_pkg::ST_RECENT] = recent;
    status[sofr_pkg::ST_CLIP] = clip_request;
    status[sofr_pkg::ST_TRIG_ON] = trig_on;
  end

  // axi4-lite read: one outstanding read
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= sofr_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= sofr_pkg::RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        sofr_pkg::OFS_CTRL: s_axi_rdata <= ctrl_q;
        sofr_pkg::OFS_STATUS: s_axi_rdata <= status;
        sofr_pkg::OFS_CLIP: s_axi_rdata <= {24'h000000, clip_q};
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= sofr_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  AST_TRIG_ON: assert property (@(posedge aclk) disable iff (!aresetn)
    (trig_on && !forced_q && !(main_conv_en && (dc_s || clip_trip))) |=>
    mode_on_q ##1 main_conv_en) // R1
    else $error("single trigger did not turn main on");
  AST_BOTH_STBY: assert property (@(posedge aclk) disable iff (!aresetn)
    (both_trig && !mode_on_q) |=> !mode_on_q) // R2
    else $error("both triggers failed to hold standby");
  AST_AUDIO_ON: assert property (@(posedge aclk) disable iff (!aresetn)
    (audio_s && !both_trig) |=> mode_on_q && inact_q == '0) // R5
    else $error("audio did not select on mode");
  AST_OFF_DELAY: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(mode_on_q) |-> $past(off_cnt_q) == W'(sofr_pkg::OFF_DELAY_MS - 1))
    else $error("main turned off without full delay"); // R6
  AST_FORCED_LEN: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(forced_q) |-> $past(force_cnt_q) == FORCED_TICKS - 1'b1) // R9
    else $error("forced off window wrong length");
  AST_DC_TRIP: assert property (@(posedge aclk) disable iff (!aresetn)
    (main_conv_en && dc_s) |=> forced_q ##1 !main_conv_en) // R10
    else $error("offset fault did not stop main");
  AST_FORCE_WINS: assert property (@(posedge aclk) disable iff (!aresetn)
    (forced_q && $past(forced_q)) |-> !main_conv_en) // R20
    else $error("main on during forced off");
  AST_AUX_STBY: assert property (@(posedge aclk) disable iff (!aresetn)
    !mode_on_q |=> !aux_conv_en) // R18
    else $error("aux enabled in standby");
  AST_CLIP_RAMP: assert property (@(posedge aclk) disable iff (!aresetn)
    (tk.ms_tick && clip_src && clip_q != sofr_pkg::CLIP_MAX) |=>
    clip_q == $past(clip_q) + 8'h01) // R13
    else $error("clip level did not step up");
  AST_LED: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 (led_on_mode != led_standby_mode)) // R17
    else $error("indicator states not distinct");
endmodule : sofr_top

// ### sofr_pkg.sv
package sofr_pkg;
  // clock and tick
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned CNT_W = 20;
  // intervals, all counted in ticks of TICK_US
  localparam int unsigned INACT_MIN = 13;
  localparam int unsigned INACT_MS = INACT_MIN * 60 * 1000;
  localparam int unsigned OFF_DELAY_MS = 200;
  localparam int unsigned FORCED_S = 9;
  localparam int unsigned FORCED_MS = FORCED_S * 1000;
  localparam int unsigned RETRY_MS = 100;
  localparam int unsigned AVG_SAFE_MS = 1000;
  localparam int unsigned CLIP_SAT_MS = 2000;
  // clip ramp
  localparam logic [7:0] CLIP_MAX = 8'hff;
  // synchronised input positions
  localparam int unsigned IN_N = 13;
  localparam int unsigned IX_HV = 0;
  localparam int unsigned IX_LL = 1;
  localparam int unsigned IX_AUDIO = 2;
  localparam int unsigned IX_HS_PRI = 3;
  localparam int unsigned IX_HS_SEC = 4;
  localparam int unsigned IX_AVG = 5;
  localparam int unsigned IX_POS_UV = 6;
  localparam int unsigned IX_NEG_UV = 7;
  localparam int unsigned IX_AUX_HOT = 8;
  localparam int unsigned IX_PUMP = 9;
  localparam int unsigned IX_DC = 10;
  localparam int unsigned IX_AUX_OC = 11;
  localparam int unsigned IX_STB_SC = 12;
  // register map
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CLIP = 8'h08;
  localparam int unsigned CTRL_SENSE_EN = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam int unsigned ST_MODE_ON = 0;
  localparam int unsigned ST_MAIN_EN = 1;
  localparam int unsigned ST_FORCED = 2;
  localparam int unsigned ST_AUX_EN = 3;
  localparam int unsigned ST_STB_RUN = 4;
  localparam int unsigned ST_STB_FULL = 5;
  localparam int unsigned ST_RECENT = 6;
  localparam int unsigned ST_CLIP = 7;
  localparam int unsigned ST_TRIG_ON = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sofr_pkg

// ### sofr_tick_if.sv
`timescale 1ns/1ns
interface sofr_tick_if;
  logic ms_tick;
  modport src (output ms_tick);
  modport dst (input ms_tick);
endinterface : sofr_tick_if

// ### sofr_tick.sv
`timescale 1ns/1ns
module sofr_tick #(
  parameter logic [sofr_pkg::CNT_W-1:0] TICK_CYCLES =
    sofr_pkg::CNT_W'(sofr_pkg::TICK_CYC)
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // tick out
  sofr_tick_if.src tk
);
  logic [sofr_pkg::CNT_W-1:0] div_q;

  // one-cycle enable every TICK_CYCLES clocks
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_q <= '0;
      tk.ms_tick <= 1'b0;
    end
    else if (div_q == TICK_CYCLES - 1'b1)
    begin
      div_q <= '0;
      tk.ms_tick <= 1'b1; // R19
    end
    else
    begin
      div_q <= div_q + 1'b1;
      tk.ms_tick <= 1'b0;
    end
  end
endmodule : sofr_tick

// ### sofr_retry.sv
`timescale 1ns/1ns
module sofr_retry (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  sofr_tick_if.dst tk,
  // control
  input wire logic en_req,
  input wire logic fault,
  output logic run_q
);
  typedef enum logic {ST_RUN, ST_OFF} sofr_retry_st_t;
  sofr_retry_st_t st_q;
  logic [sofr_pkg::CNT_W-1:0] cnt_q;

  // a short seen while running costs one off window, then retry
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= ST_RUN;
      cnt_q <= '0;
    end
    else
    begin
      unique case (st_q)
        ST_RUN:
        begin
          cnt_q <= '0;
          if (en_req && fault)
            st_q <= ST_OFF; // R14 R15
        end
        ST_OFF:
        begin
          if (tk.ms_tick)
          begin
            if (cnt_q == sofr_pkg::CNT_W'(sofr_pkg::RETRY_MS - 1))
              st_q <= ST_RUN; // R14 R15
            else
              cnt_q <= cnt_q + 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      run_q <= 1'b0;
    else
      run_q <= en_req && (st_q == ST_RUN) && !fault;
  end

  AST_RETRY_OFF: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_q == ST_RUN && en_req && fault) |=> ##1 !run_q [*2]) // R14
    else $error("converter not held off after short");
endmodule : sofr_retry

// ### sofr_ctl_model.sv
`timescale 1ns/1ns
module sofr_ctl_model (
  // clock
  input wire logic aclk,
  // command from bench: bit1 high-voltage line, bit0 logic-level line
  input wire logic [1:0] cmd,
  input wire logic [3:0] lag,
  // trigger lines
  output logic hv_trigger_input,
  output logic logic_level_trigger_input
);
  logic [3:0] wait_q;
  initial
  begin
    hv_trigger_input = 1'b0;
    logic_level_trigger_input = 1'b0;
    wait_q = 4'h0;
  end
  // a slow controller settles both lines lag cycles after it decides
  always @(posedge aclk)
  begin
    if ({hv_trigger_input, logic_level_trigger_input} == cmd)
      wait_q <= 4'h0;
    else if (wait_q >= lag)
    begin
      hv_trigger_input <= cmd[1];
      logic_level_trigger_input <= cmd[0];
    end
    else
      wait_q <= wait_q + 4'h1;
  end
endmodule : sofr_ctl_model

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
  localparam int TK = 4;
  localparam int IN = 50;
  localparam int FO = 20;
  localparam int RT = sofr_pkg::RETRY_MS;
  localparam int AV = sofr_pkg::AVG_SAFE_MS;
  localparam int SA = sofr_pkg::CLIP_SAT_MS;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic [3:0] lag = 4'h0;
  // 0..5 clip sources, 6 avg, 7 offset, 8 aux short, 9 standby short, 10 audio
  logic [10:0] flt = 11'h0;
  logic hv, ll, m_en, a_en, s_en, s_full, clip_r, led_on, led_sb;
  logic [7:0] clip_lv;
  logic [7:0] awaddr = 8'h0;
  logic [7:0] araddr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic brdy = 1'b0;
  logic arv = 1'b0;
  logic rrdy = 1'b0;
  logic [1:0] bresp, rresp;
  logic awr, wr, bv, arr, rv;
  int failures = 0;
  int samples_checked = 0;

  always #25 aclk = ~aclk;

  sofr_ctl_model u_sofr_ctl_model (.aclk(aclk), .cmd(cmd), .lag(lag),
    .hv_trigger_input(hv), .logic_level_trigger_input(ll));

  // short intervals keep the run small; expectations use the same values
  sofr_top #(.TICK_CYCLES(20'h4), .INACT_TICKS(20'h32),
    .FORCED_TICKS(20'h14)) u_sofr_top (
    .aclk(aclk), .aresetn(aresetn), .hv_trigger_input(hv),
    .logic_level_trigger_input(ll), .audio_detect(flt[10]),
    .heatsink_pri_hot(flt[0]), .heatsink_sec_hot(flt[1]),
    .positive_power_rail_low(flt[2]), .negative_power_rail_low(flt[3]),
    .aux_device_hot(flt[4]), .pump_cancel_overcurrent(flt[5]),
    .avg_current_high(flt[6]), .amp_dc_offset(flt[7]),
    .aux_overcurrent(flt[8]), .standby_rail_short(flt[9]),
    .main_conv_en(m_en), .aux_conv_en(a_en), .standby_rail_en(s_en),
    .standby_full_power(s_full), .clip_request(clip_r),
    .clip_level(clip_lv), .led_on_mode(led_on), .led_standby_mode(led_sb),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(brdy), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rrdy));

  function automatic logic sig(input int i);
    case (i)
      0: return m_en;
      1: return a_en;
      2: return s_en;
      default: return clip_r;
    endcase
  endfunction : sig

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string what);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic rng(input int n, input int lo, input int hi,
    input string what);
    samples_checked++;
    if (n < lo || n > hi)
    begin
      failures++;
      $display("MISMATCH t=%0t %s took %0d cycles", $time, what, n);
    end
  endtask : rng

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  // bounded wait on a design output, counted in clock cycles
  task automatic wt(input int i, input logic v, input int lim, output int n);
    n = 0;
    @(negedge aclk);
    while (sig(i) !== v && n < lim)
    begin
      @(negedge aclk);
      n++;
    end
    if (n >= lim)
    begin
      failures++;
      $display("MISMATCH t=%0t wait on output %0d timed out", $time, i);
      results();
    end
  endtask : wt

  task automatic setf(input int i, input logic v);
    @(posedge aclk);
    flt <= v ? (flt | (11'h1 << i)) : (flt & ~(11'h1 << i));
  endtask : setf

  task automatic setc(input logic [1:0] c);
    @(posedge aclk);
    cmd <= c;
  endtask : setc

  // handshakes are judged at the negedge, acted on at the next posedge
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
    output logic [1:0] r);
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    repeat (200)
    begin
      @(negedge aclk);
      ta = awv & awr;
      tw = wv & wr;
      tb = bv;
      r = bresp;
      @(posedge aclk);
      if (ta)
        awv <= 1'b0;
      if (tw)
        wv <= 1'b0;
      if (tb)
      begin
        brdy <= 1'b0;
        break;
      end
    end
    if (tb !== 1'b1)
    begin
      failures++;
      $display("MISMATCH t=%0t write response missing", $time);
      results();
    end
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    logic ta, tb;
    tb = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    repeat (200)
    begin
      @(negedge aclk);
      ta = arv & arr;
      tb = rv;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta)
        arv <= 1'b0;
      if (tb)
      begin
        rrdy <= 1'b0;
        break;
      end
    end
    if (tb !== 1'b1)
    begin
      failures++;
      $display("MISMATCH t=%0t read data missing", $time);
      results();
    end
  endtask : axr

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    axr(sofr_pkg::OFS_CTRL, d, r);
    chk(d, sofr_pkg::CTRL_RESET, "ctrl reset");
    axr(sofr_pkg::OFS_STATUS, d, r);
    chk(d, 32'h1 << sofr_pkg::ST_STB_RUN, "status reset");
    chk({m_en, a_en, s_full, led_on, led_sb}, 32'h1, "outputs idle");
    axr(8'h0c, d, r);
    chk({r, d}, {sofr_pkg::RESP_SLVERR, 32'h0}, "unmapped read");
    axw(sofr_pkg::OFS_STATUS, 32'hffff_ffff, r);
    axr(sofr_pkg::OFS_STATUS, d, r);
    chk(d, 32'h1 << sofr_pkg::ST_STB_RUN, "status read only");
    // with sensing off the audio comparator must be ignored
    axw(sofr_pkg::OFS_CTRL, 32'h0, r);
    chk(r, sofr_pkg::RESP_OKAY, "ctrl write");
    setf(10, 1'b1);
    repeat (40) @(negedge aclk);
    chk(m_en, 1'b0, "audio ignored");
    setf(10, 1'b0);
    axw(sofr_pkg::OFS_CTRL, 32'h1, r);
    $display("test regs done");
  endtask : t_regs

  task automatic t_trig;
    int n;
    lag <= 4'h3;
    setc(2'b10);
    wt(0, 1'b1, 60, n);
    // aux enable follows main by one more register stage
    @(negedge aclk);
    chk({a_en, s_full, led_on, led_sb}, 32'he, "on outputs");
    setc(2'b01);
    repeat (10 * TK) @(negedge aclk);
    chk(m_en, 1'b1, "other trigger alone");
    setc(2'b11);
    wt(0, 1'b0, 1200, n);
    rng(n, 199 * TK, 201 * TK + 12, "off delay");
    chk({a_en, s_full, led_on, led_sb}, 32'h1, "standby outputs");
    setf(10, 1'b1);
    repeat (60) @(negedge aclk);
    chk(m_en, 1'b0, "both high beat audio");
    setf(10, 1'b0);
    setc(2'b00);
    wt(0, 1'b1, 60, n);
    wt(0, 1'b0, 1500, n);
    lag <= 4'h0;
    $display("test triggers done");
  endtask : t_trig

  task automatic t_audio;
    int n;
    setf(10, 1'b1);
    wt(0, 1'b1, 40, n);
    repeat (30 * TK) @(negedge aclk);
    chk(m_en, 1'b1, "audio holds on");
    setf(10, 1'b0);
    repeat (30 * TK) @(negedge aclk);
    setf(10, 1'b1);
    repeat (2 * TK) @(negedge aclk);
    setf(10, 1'b0);
    wt(0, 1'b0, 1500, n);
    rng(n, (IN + 199) * TK, (IN + 201) * TK + 12, "inactivity");
    $display("test audio done");
  endtask : t_audio

  task automatic t_dc;
    int n;
    setc(2'b10);
    wt(0, 1'b1, 60, n);
    setf(7, 1'b1);
    wt(0, 1'b0, 10, n);
    wt(0, 1'b1, FO * TK + 40, n);
    rng(n, (FO - 1) * TK, FO * TK + 12, "offset off time");
    wt(0, 1'b0, 10, n);
    setf(7, 1'b0);
    wt(0, 1'b1, FO * TK + 40, n);
    $display("test offset done");
  endtask : t_dc

  task automatic t_clip;
    int n;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 6; i++)
    begin
      setf(i, 1'b1);
      wt(3, 1'b1, TK + 12, n);
      repeat (10 * TK) @(negedge aclk);
      rng(clip_lv, 9, 12, "clip ramp");
      chk(m_en, 1'b1, "playing on");
      setf(i, 1'b0);
      wt(3, 1'b0, 20 * TK, n);
    end
    setf(6, 1'b1);
    wt(3, 1'b1, (AV + 5) * TK, n);
    rng(n, (AV - 1) * TK, AV * TK + TK + 12, "average hold");
    wt(0, 1'b0, (SA + 260) * TK, n);
    rng(n, (SA + 253) * TK, (SA + 256) * TK + 12, "clip saturated");
    axr(sofr_pkg::OFS_STATUS, d, r);
    chk(d[sofr_pkg::ST_FORCED], 1'b1, "forced flag");
    setf(6, 1'b0);
    wt(0, 1'b1, FO * TK + 40, n);
    rng(n, (FO - 2) * TK, FO * TK + 12, "forced restart");
    $display("test clip done");
  endtask : t_clip

  task automatic t_retry;
    int n;
    for (int j = 0; j < 2; j++)
    begin
      setf(8 + j, 1'b1);
      wt(1 + j, 1'b0, 10, n);
      repeat (3 * TK) @(negedge aclk);
      setf(8 + j, 1'b0);
      wt(1 + j, 1'b1, (RT + 5) * TK, n);
      rng(n, (RT - 6) * TK, RT * TK + 12, "retry pause");
    end
    setc(2'b00);
    $display("test retry done");
  endtask : t_retry

  initial
  begin
    repeat (20) @(posedge aclk);
    chk({s_en, led_sb}, 32'h1, "in reset");
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_trig();
    t_audio();
    t_dc();
    t_clip();
    t_retry();
    results();
  end
endmodule : testbench
